/* hw/shift_port_pkg.sv */
// constants for the synchronous serial shift port
package shift_port_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 3;
   localparam int unsigned DIV_W = 4;
   localparam int unsigned DIV_CNT_W = 14;
   localparam logic [DIV_W-1:0] DIV_MIN = 4'h1;
   localparam logic [DIV_W-1:0] DIV_MAX = 4'hf;
   localparam logic [DATA_W-1:0] SHIFT_RESET = 8'h00;
   localparam logic [DIV_W-1:0] DIV_RESET = 4'h1;
   localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
   localparam int unsigned REF_CLK_MHZ = 125;
   localparam int unsigned BUF_DEPTH = 2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOW,
      ST_HIGH
   } shift_state_e;

   // half period of the shift clock, less one, in ref_clk cycles for a divider setting
   function automatic logic [DIV_CNT_W-1:0] half_period(input logic [DIV_W-1:0] sel);
      logic [DIV_W-1:0] s;
      s = (sel < DIV_MIN) ? DIV_MIN : sel;
      half_period = DIV_CNT_W'(DIV_CNT_W'(4) << (DIV_MAX - s));
   endfunction : half_period
endpackage : shift_port_pkg

/* hw/byte_stream_if.sv */
// valid/ready byte stream between the shift engine and its buffer
`timescale 1ns/1ns
interface byte_stream_if;
   logic valid;
   logic ready;
   logic [shift_port_pkg::DATA_W-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface : byte_stream_if

/* hw/two_entry_buffer.sv */
// two-entry buffer for received bytes
`timescale 1ns/1ns
module two_entry_buffer (
   input wire logic ref_clk,
   input wire logic rst_n,
   byte_stream_if.sink in_s,
   output logic out_valid,
   input wire logic out_ready,
   output logic [shift_port_pkg::DATA_W-1:0] out_data
);
   logic [shift_port_pkg::DATA_W-1:0] mem_reg [shift_port_pkg::BUF_DEPTH];
   logic [shift_port_pkg::DATA_W-1:0] mem_next [shift_port_pkg::BUF_DEPTH];
   logic [1:0] count_reg, count_next;
   logic push, pop;

   // -----------------------------
   // occupancy and handshakes
   // -----------------------------
   assign in_s.ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = mem_reg[0];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_valid && out_ready;

   // head at entry 0, shift forward on pop
   always_comb begin
      mem_next = mem_reg;
      count_next = count_reg;
      if (pop) begin
         mem_next[0] = mem_reg[1];
         count_next = count_next - 2'h1;
      end
      if (push) begin
         mem_next[(pop ? count_reg - 2'h1 : count_reg) == 2'h0 ? 0 : 1] = in_s.data;
         count_next = count_next + 2'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_reg[0] <= shift_port_pkg::SHIFT_RESET;
         mem_reg[1] <= shift_port_pkg::SHIFT_RESET;
         count_reg <= 2'h0;
      end else begin
         mem_reg <= mem_next;
         count_reg <= count_next;
      end
   end
endmodule : two_entry_buffer

/* hw/sync_serial_shift_port.sv */
// synchronous serial shift port: 8-bit shift register, master or slave clock
`timescale 1ns/1ns
module sync_serial_shift_port (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic master_mode,
   input wire logic [shift_port_pkg::DIV_W-1:0] clock_divider_register,
   input wire logic shift_wr,
   input wire logic [shift_port_pkg::DATA_W-1:0] shift_wdata,
   input wire logic start,
   input wire logic done_clear,
   output logic [shift_port_pkg::DATA_W-1:0] serial_shift_register,
   output logic done,
   output logic busy,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [shift_port_pkg::DATA_W-1:0] rx_data,
   input wire logic shift_clock_pin_in,
   output logic shift_clock_pin_out,
   output logic shift_clock_pin_oe,
   input wire logic serial_in,
   output logic serial_out
);
   shift_port_pkg::shift_state_e state_reg, state_next;
   logic [shift_port_pkg::DATA_W-1:0] shift_reg, shift_next;
   logic [shift_port_pkg::CNT_W-1:0] bit_reg, bit_next;
   logic [shift_port_pkg::DIV_CNT_W-1:0] div_reg, div_next;
   logic sck_reg, sck_next;
   logic so_reg, so_next;
   logic done_reg, done_next;
   logic ext_prev_reg;
   logic ext_prev_next;
   logic rise, fall, last_rise;
   byte_stream_if rx_s ();

   // -----------------------------
   // received byte buffer
   // -----------------------------
   two_entry_buffer u_rx_buf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_s(rx_s.sink),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // -----------------------------
   // shift clock edges
   // -----------------------------
   // master: divider expiry toggles own clock; slave: edges of the pin
   always_comb begin
      if (master_mode) begin
         rise = (state_reg == shift_port_pkg::ST_LOW) && (div_reg == '0);
         fall = (state_reg == shift_port_pkg::ST_HIGH) && (div_reg == '0);
      end else begin
         rise = (state_reg != shift_port_pkg::ST_IDLE) && shift_clock_pin_in && !ext_prev_reg;
         fall = (state_reg != shift_port_pkg::ST_IDLE) && !shift_clock_pin_in && ext_prev_reg;
      end
   end
   assign last_rise = rise && (bit_reg == shift_port_pkg::LAST_BIT);
   // a full buffer stalls the final sample in master mode
   assign rx_s.valid = last_rise;
   assign rx_s.data = {shift_reg[shift_port_pkg::DATA_W-2:0], serial_in};

   // -----------------------------
   // transfer engine
   // -----------------------------
   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      bit_next = bit_reg;
      div_next = div_reg;
      sck_next = sck_reg;
      so_next = so_reg;
      done_next = done_reg;
      if (done_clear) begin
         done_next = 1'b0;
      end
      if (master_mode && state_reg != shift_port_pkg::ST_IDLE && div_reg != '0) begin
         div_next = div_reg - 1'b1;
      end
      case (state_reg)
         shift_port_pkg::ST_IDLE: begin
            sck_next = 1'b0;
            if (shift_wr) begin
               shift_next = shift_wdata;
               so_next = shift_wdata[shift_port_pkg::DATA_W-1];
            end else if (start) begin
               state_next = shift_port_pkg::ST_LOW;
               bit_next = '0;
               done_next = 1'b0;
               so_next = shift_reg[shift_port_pkg::DATA_W-1];
               div_next = shift_port_pkg::half_period(clock_divider_register);
            end
         end
         shift_port_pkg::ST_LOW: begin
            if (rise && (!last_rise || rx_s.ready || !master_mode)) begin
               shift_next = {shift_reg[shift_port_pkg::DATA_W-2:0], serial_in};
               sck_next = 1'b1;
               div_next = shift_port_pkg::half_period(clock_divider_register);
               if (last_rise) begin
                  state_next = shift_port_pkg::ST_IDLE;
                  done_next = 1'b1;
                  // the eighth rise still reaches the pin; idle pulls it low next cycle
               end else begin
                  state_next = shift_port_pkg::ST_HIGH;
                  bit_next = bit_reg + 1'b1;
               end
            end
         end
         shift_port_pkg::ST_HIGH: begin
            if (fall) begin
               so_next = shift_reg[shift_port_pkg::DATA_W-1];
               sck_next = 1'b0;
               state_next = shift_port_pkg::ST_LOW;
               div_next = shift_port_pkg::half_period(clock_divider_register);
            end
         end
         default: begin
            state_next = shift_port_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= shift_port_pkg::ST_IDLE;
         shift_reg <= shift_port_pkg::SHIFT_RESET;
         bit_reg <= '0;
         div_reg <= '0;
         sck_reg <= 1'b0;
         so_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         bit_reg <= bit_next;
         div_reg <= div_next;
         sck_reg <= sck_next;
         so_reg <= so_next;
         done_reg <= done_next;
      end
   end

   // -----------------------------
   // pin history for slave edges
   // -----------------------------
   // previous pin level; reset low so an idle low pin gives no false edge
   always_comb begin
      ext_prev_next = shift_clock_pin_in;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= ext_prev_next;
      end
   end

   // -----------------------------
   // usage limits
   // -----------------------------
   // a load or a start while busy is ignored, so software waits for busy low
   // a start with a load in the same cycle loses: only the load is taken
   // a clear of the done flag in the completion cycle loses: the set wins
   // the done flag also drops at the next start, so no stale completion is seen
   // in master mode the last sample waits while the receive buffer is full,
   // which stretches the low phase of the eighth clock instead of losing a byte
   // in slave mode the far side owns the clock, so a full buffer drops the byte
   // slave pin edges are seen one ref_clk later; the pin must stay in each
   // level for at least one ref_clk cycle or an edge is missed
   // the pin is taken as synchronous; an asynchronous source needs a synchroniser
   // outside this block
   // a divider setting of zero is treated as setting 1 (DIV_MIN)
   // the divider is read at every half period, so a change takes effect at the
   // next shift clock edge and may give one odd-length phase
   // the shift clock stays low outside transfers; after the eighth sample it is
   // high for one ref_clk cycle before it returns low
   // serial_out holds the last bit sent until the next load or start
   // the master-mode output enable follows master_mode with no delay, so the
   // mode should only change while idle

   // -----------------------------
   // outputs
   // -----------------------------
   assign serial_shift_register = shift_reg;
   assign done = done_reg;
   assign busy = (state_reg != shift_port_pkg::ST_IDLE);
   assign serial_out = so_reg;
   assign shift_clock_pin_out = sck_reg;
   assign shift_clock_pin_oe = master_mode;
endmodule : sync_serial_shift_port

/* tb/link_peer.sv */
// far-side peripheral model for the serial link
`timescale 1ns/1ns
module link_peer (
   input wire logic sck,
   input wire logic load,
   input wire logic [7:0] load_val,
   input wire logic from_port,
   output logic to_port,
   output logic [7:0] got
);
   logic [7:0] tx_reg = 8'h00;
   // ----
   // shifting
   // ----
   // preset by load, next bit on the falling clock
   always @(negedge sck or posedge load) tx_reg <= load ? load_val : {tx_reg[6:0], ~tx_reg[0]};
   // capture on the rising clock
   always @(posedge sck) got <= {got[6:0], from_port};
   assign to_port = tx_reg[7]; // msb first
endmodule : link_peer

/* tb/shift_port_props.sv */
// concurrent checks on the shift port's pins, flags and shift register
`timescale 1ns/1ns
module shift_port_props (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic master_mode,
   input wire logic [3:0] clock_divider_register,
   input wire logic shift_wr,
   input wire logic [7:0] shift_wdata,
   input wire logic start,
   input wire logic done_clear,
   input wire logic [7:0] serial_shift_register,
   input wire logic done,
   input wire logic busy,
   input wire logic shift_clock_pin_out,
   input wire logic shift_clock_pin_oe,
   input wire logic serial_out
);
   // ----
   // checks
   // ----
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // pin direction, start, clear and load
   oe_mode_a: assert property (shift_clock_pin_oe == master_mode) else $error("oe");
   start_busy_a: assert property (start && !busy && !shift_wr |=> busy) else $error("busy");
   clear_done_a: assert property (done_clear && !busy |=> !done) else $error("clear");
   load_reg_a: assert property (shift_wr && !busy |=> serial_shift_register == $past(shift_wdata))
      else $error("load");
   // shift clock shape, data edge and end of transfer
   data_fall_a: assert property (master_mode && busy && $changed(serial_out) |-> !shift_clock_pin_out)
      else $error("edge");
   idle_low_a: assert property (master_mode && !busy && !$past(busy) |-> !shift_clock_pin_out)
      else $error("idle");
   low_phase_a: assert property (master_mode && busy && clock_divider_register == 4'hf
      && $fell(shift_clock_pin_out) |-> !shift_clock_pin_out [*4]) else $error("rate");
   done_end_a: assert property ($rose(done) |-> $fell(busy)) else $error("done");
   cover property (master_mode && $rose(done));
   cover property (!master_mode && $rose(done));
   cover property (done_clear && done);
endmodule : shift_port_props

bind sync_serial_shift_port shift_port_props shift_port_props_inst (.*);

/* tb/tb_top.sv */
// self-checking bench for the serial shift port
`timescale 1ns/1ns
module tb_top;
   logic ref_clk = 1'b0, rst_n = 1'b0, master_mode = 1'b1, shift_wr = 1'b0, start = 1'b0;
   logic done_clear = 1'b0, rx_ready = 1'b1, slv_clk = 1'b0, load = 1'b0;
   logic [3:0] clock_divider_register = 4'hf;
   logic [7:0] shift_wdata = 8'h00, peer_val = 8'h00, serial_shift_register, rx_data, got;
   logic done, busy, rx_valid, shift_clock_pin_out, shift_clock_pin_oe, serial_out, serial_in, shift_clock_pin_in;
   logic [7:0] q[$];
   int err_count = 0, n_tests = 0;
   // ----
   // harness
   // ----
   assign shift_clock_pin_in = shift_clock_pin_oe ? shift_clock_pin_out : slv_clk; // pin level
   initial forever #4 ref_clk = ~ref_clk;
   sync_serial_shift_port sync_serial_shift_port_inst (.*);
   link_peer link_peer_inst (.sck(shift_clock_pin_in), .load(load), .load_val(peer_val), .from_port(serial_out),
      .to_port(serial_in), .got(got));
   task automatic complete_run;
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic check8(input logic [7:0] act, input logic [7:0] exp);
      n_tests++;
      if (act !== exp) begin
         err_count++;
         $display("FAIL %0t got %h want %h", $time, act, exp);
      end
   endtask : check8
   // one transfer; stall holds the third word until the drain opens
   task automatic xfer(input bit stall);
      logic [7:0] t;
      logic [7:0] p;
      int i;
      t = 8'($urandom);
      p = 8'($urandom);
      @(posedge ref_clk);
      shift_wdata <= t;
      peer_val <= p;
      shift_wr <= 1'b1;
      load <= 1'b1;
      @(posedge ref_clk);
      shift_wr <= 1'b0;
      load <= 1'b0;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      shift_wr <= 1'b1; // refused while busy
      shift_wdata <= ~t;
      q.push_back(p);
      @(posedge ref_clk);
      shift_wr <= 1'b0;
      for (i = 0; i < 16 && !master_mode; i++) begin
         repeat (20) @(posedge ref_clk);
         slv_clk <= ~slv_clk; // far side clocks the slave
      end
      if (stall) begin
         repeat (150) @(posedge ref_clk);
         check8({6'h00, busy, done}, 8'h02);
         rx_ready <= 1'b1;
      end
      for (i = 0; i < 400 && done !== 1'b1; i++) @(posedge ref_clk);
      @(negedge ref_clk);
      check8({7'h00, done}, 8'h01);
      check8(got, t);
      check8(serial_shift_register, p);
      if (done !== 1'b1) complete_run();
      @(posedge ref_clk);
      done_clear <= 1'b1;
      @(posedge ref_clk);
      done_clear <= 1'b0;
      @(negedge ref_clk);
      check8({7'h00, done}, 8'h00);
   endtask : xfer
   // received words against the model queue
   always @(posedge ref_clk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) check8(rx_data, q.pop_front());
   end
   initial begin
      void'($urandom(32'h9c5ff975));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int s = 15; s > 12; s--) begin
         clock_divider_register <= 4'(s);
         xfer(1'b0);
      end
      clock_divider_register <= 4'hf;
      rx_ready <= 1'b0;
      xfer(1'b0);
      xfer(1'b0);
      xfer(1'b1);
      master_mode <= 1'b0;
      xfer(1'b0);
      repeat (10) @(posedge ref_clk);
      check8(8'(q.size()), 8'h00);
      complete_run();
   end
endmodule : tb_top
